// ---- inc/cmpwm_consts.svh ----
// What this block does
// - Divide oscillator by four through two toggles
// - Half-duty window is inverted second stage
// - Three-quarter window is NAND of both stages
// - Soft-start waits at zero during lockout
// - Reference climbs staircase to final, then holds
// - Current-sense trip ends on-phase promptly
// - Supply sag before startup returns to lockout
// - Every lockout exit restarts fresh soft-start
// - No-bootstrap variant runs on enable, gate-supply
// - Lockout stops comparators, oscillator and gate drive
`ifndef CMPWM_CONSTS_SVH
`define CMPWM_CONSTS_SVH

// Clock rates in kHz
`define CMPWM_CORE_CLK_KHZ 250000
`define CMPWM_OSC_KHZ 1048
// Core cycles per oscillator period (rounded down)
`define CMPWM_OSC_DIV (`CMPWM_CORE_CLK_KHZ / `CMPWM_OSC_KHZ)

// Soft-start timing
`define CMPWM_SS_TIME_MS 60
`define CMPWM_SS_TIME_CYC (`CMPWM_SS_TIME_MS * `CMPWM_CORE_CLK_KHZ)
// Reference steps from zero to the final code
`define CMPWM_SS_STEPS 31
`define CMPWM_REF_W 5
`define CMPWM_REF_RESET 5'h00

// Current-limit response bound, longest time so rounded down
`define CMPWM_CL_RESP_NS 60
`define CMPWM_CLK_PERIOD_NS 4
`define CMPWM_CL_RESP_CYC (`CMPWM_CL_RESP_NS / `CMPWM_CLK_PERIOD_NS)
// Cycles from a registered trip input to gate low
`define CMPWM_CL_LATENCY_CYC 1

// Widths of the internal counters
`define CMPWM_PRE_W 16
`define CMPWM_DWELL_W 32

// One-hot state codes
`define CMPWM_ST_LOCKOUT 3'h1
`define CMPWM_ST_SOFT 3'h2
`define CMPWM_ST_RUN 3'h4

`endif

// ---- inc/cmpwm_pkg.sv ----
`include "cmpwm_consts.svh"

package cmpwm_pkg;

    // Operating state, one-hot
    typedef enum logic [2:0] {
        CMPWM_LOCKOUT = `CMPWM_ST_LOCKOUT,
        CMPWM_SOFT = `CMPWM_ST_SOFT,
        CMPWM_RUN = `CMPWM_ST_RUN
    } cmpwm_state_t;

    // Comparator results and supply conditions, all synchronous
    typedef struct packed {
        logic enable_lockout_input;
        logic supply_above_wake;
        logic supply_above_low;
        logic gate_supply_ok;
        logic current_limit_comparator;
        logic pwm_comparator;
    } cmpwm_sense_t;

    // Status seen from outside
    typedef struct packed {
        logic undervoltage_lockout;
        logic soft_start_done;
        logic [`CMPWM_REF_W-1:0] ref_code;
    } cmpwm_status_t;

endpackage

// ---- src/cmpwm_toggle.sv ----
// One divider stage: toggles on each enabled tick, cleared while stopped
module cmpwm_toggle (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic clear_in,
    input wire logic toggle_in,
    output logic q_out,
    output logic q_nxt_out
);
    import cmpwm_pkg::*;

    logic q_r;
    logic q_nxt;

    // Clear has priority so a stopped oscillator restarts from phase zero
    always_comb begin
        q_nxt = q_r;
        if (clear_in) begin
            q_nxt = 1'b0;
        end else if (toggle_in) begin
            q_nxt = ~q_r;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q_r <= 1'b0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q_out = q_r;
    assign q_nxt_out = q_nxt;
endmodule // cmpwm_toggle

// ---- src/cmpwm_core.sv ----
`include "cmpwm_consts.svh"

// Timing core of a current-mode PWM controller
module cmpwm_core #(
    parameter bit BOOTSTRAP_LOCKOUT = 1'b1,
    parameter bit THREE_QUARTER_DUTY = 1'b0,
    parameter int unsigned OSC_DIV = `CMPWM_OSC_DIV,
    parameter int unsigned SS_TIME_CYCLES = `CMPWM_SS_TIME_CYC,
    parameter int unsigned SS_STEPS = `CMPWM_SS_STEPS
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire cmpwm_pkg::cmpwm_sense_t sense_in,
    output logic gate_drive_output_out,
    output cmpwm_pkg::cmpwm_status_t status_out
);
    import cmpwm_pkg::*;

    localparam int unsigned SS_DWELL = SS_TIME_CYCLES / SS_STEPS;

    // Refuse settings the counters or the current-limit response bound cannot serve
    generate
        if (OSC_DIV < 2 || OSC_DIV > 65535) begin : g_bad_div
            $error("OSC_DIV must be within 2 to 65535");
        end
        if (SS_STEPS < 1 || SS_STEPS > (1 << `CMPWM_REF_W) - 1) begin : g_bad_steps
            $error("SS_STEPS does not fit the reference code");
        end
        if (SS_DWELL < 1) begin : g_bad_dwell
            $error("SS_TIME_CYCLES too small for the step count");
        end
        if (`CMPWM_CL_LATENCY_CYC > `CMPWM_CL_RESP_CYC) begin : g_bad_resp
            $error("Current-limit latency exceeds its bound");
        end
    endgenerate

    cmpwm_state_t state_r;
    cmpwm_state_t state_nxt;
    logic [`CMPWM_PRE_W-1:0] pre_r;
    logic [`CMPWM_PRE_W-1:0] pre_nxt;
    logic [`CMPWM_DWELL_W-1:0] dwell_r;
    logic [`CMPWM_DWELL_W-1:0] dwell_nxt;
    logic [`CMPWM_REF_W-1:0] ref_r;
    logic [`CMPWM_REF_W-1:0] ref_nxt;
    logic term_r;
    logic term_nxt;
    logic gate_r;
    logic gate_nxt;
    logic lockout_r;
    logic lockout_nxt;
    logic done_r;
    logic done_nxt;
    logic osc_stop;
    logic osc_tick;
    logic stage1_q;
    logic stage1_nxt;
    logic stage2_q;
    logic stage2_nxt;
    logic stage2_tick;
    logic window_nxt;
    logic period_start;
    logic release_ok;
    logic fall_back;
    logic trip;

    // Release and fall-back conditions differ per variant
    always_comb begin
        if (BOOTSTRAP_LOCKOUT) begin
            release_ok = sense_in.enable_lockout_input && sense_in.supply_above_wake;
            fall_back = !sense_in.enable_lockout_input || !sense_in.supply_above_low;
        end else begin
            release_ok = sense_in.enable_lockout_input && sense_in.gate_supply_ok;
            fall_back = !sense_in.enable_lockout_input || !sense_in.gate_supply_ok;
        end
    end

    // Lockout, soft-start and run sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CMPWM_LOCKOUT: begin
                if (release_ok) begin
                    state_nxt = CMPWM_SOFT;
                end
            end
            CMPWM_SOFT: begin
                if (fall_back) begin
                    state_nxt = CMPWM_LOCKOUT;
                end else if (ref_r == `CMPWM_REF_W'(SS_STEPS)) begin
                    state_nxt = CMPWM_RUN;
                end
            end
            CMPWM_RUN: begin
                if (fall_back) begin
                    state_nxt = CMPWM_LOCKOUT;
                end
            end
            default: begin
                state_nxt = CMPWM_LOCKOUT;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= CMPWM_LOCKOUT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Oscillator stands still in lockout to save current
    assign osc_stop = (state_r == CMPWM_LOCKOUT);

    // Prescaler models the base oscillator from the core clock
    always_comb begin
        pre_nxt = pre_r;
        osc_tick = 1'b0;
        if (osc_stop) begin
            pre_nxt = '0;
        end else if (pre_r == `CMPWM_PRE_W'(OSC_DIV - 1)) begin
            pre_nxt = '0;
            osc_tick = 1'b1;
        end else begin
            pre_nxt = pre_r + `CMPWM_PRE_W'(1);
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_nxt;
        end
    end

    // Two toggle stages divide the base clock by four
    assign stage2_tick = osc_tick && stage1_q;

    cmpwm_toggle u_stage1 (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .clear_in(osc_stop),
        .toggle_in(osc_tick),
        .q_out(stage1_q),
        .q_nxt_out(stage1_nxt)
    );

    cmpwm_toggle u_stage2 (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .clear_in(osc_stop),
        .toggle_in(stage2_tick),
        .q_out(stage2_q),
        .q_nxt_out(stage2_nxt)
    );

    // Maximum on-time window, taken from next stage values to save a cycle
    always_comb begin
        if (THREE_QUARTER_DUTY) begin
            window_nxt = ~(stage1_nxt & stage2_nxt);
        end else begin
            window_nxt = ~stage2_nxt;
        end
    end

    // New switching period begins when both stages wrap to zero
    assign period_start = osc_tick && stage1_q && stage2_q;

    // Comparators are ignored in lockout
    assign trip = !osc_stop
        && (sense_in.current_limit_comparator || sense_in.pwm_comparator);

    // Termination latch: trip sets it, next period clears it, set wins
    always_comb begin
        term_nxt = term_r;
        if (osc_stop) begin
            term_nxt = 1'b0;
        end else if (trip) begin
            term_nxt = 1'b1;
        end else if (period_start) begin
            term_nxt = 1'b0;
        end
    end

    // Gate opens on the release edge and shuts on the fall-back edge
    // Follows window unless terminated; a trip drops it next edge
    always_comb begin
        gate_nxt = 1'b0;
        if (state_nxt != CMPWM_LOCKOUT && window_nxt && !trip) begin
            gate_nxt = !term_r || period_start;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            term_r <= 1'b0;
            gate_r <= 1'b0;
        end else begin
            term_r <= term_nxt;
            gate_r <= gate_nxt;
        end
    end

    // Staircase reference; any lockout resets it for a fresh ramp
    always_comb begin
        dwell_nxt = dwell_r;
        ref_nxt = ref_r;
        if (state_r == CMPWM_LOCKOUT) begin
            dwell_nxt = '0;
            ref_nxt = `CMPWM_REF_RESET;
        end else if (ref_r == `CMPWM_REF_W'(SS_STEPS)) begin
            dwell_nxt = '0;
        end else if (dwell_r == `CMPWM_DWELL_W'(SS_DWELL - 1)) begin
            dwell_nxt = '0;
            ref_nxt = ref_r + `CMPWM_REF_W'(1);
        end else begin
            dwell_nxt = dwell_r + `CMPWM_DWELL_W'(1);
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dwell_r <= '0;
            ref_r <= `CMPWM_REF_RESET;
        end else begin
            dwell_r <= dwell_nxt;
            ref_r <= ref_nxt;
        end
    end

    // Status flags registered so outputs come straight from flops
    always_comb begin
        lockout_nxt = (state_nxt == CMPWM_LOCKOUT);
        done_nxt = (state_nxt == CMPWM_RUN);
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lockout_r <= 1'b1;
            done_r <= 1'b0;
        end else begin
            lockout_r <= lockout_nxt;
            done_r <= done_nxt;
        end
    end

    assign gate_drive_output_out = gate_r;
    assign status_out.undervoltage_lockout = lockout_r;
    assign status_out.soft_start_done = done_r;
    assign status_out.ref_code = ref_r;
endmodule // cmpwm_core

// ---- tb/cmpwm_assertions.sv ----
// Checker on the timing core ports
module cmpwm_chk #(
    parameter bit BOOTSTRAP_LOCKOUT = 1'b1,
    parameter bit THREE_QUARTER_DUTY = 1'b0,
    parameter int unsigned OSC_DIV = 4
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire cmpwm_pkg::cmpwm_sense_t sense_in,
    input wire logic gate_drive_output_out,
    input wire cmpwm_pkg::cmpwm_status_t status_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import cmpwm_pkg::*;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    logic lk;
    logic g;
    logic [7:0] hi_r;
    logic [7:0] hi_nxt;
    assign lk = status_out.undervoltage_lockout;
    assign g = gate_drive_output_out;
    // Length of the present gate pulse
    always_comb begin
        hi_nxt = g ? hi_r + 8'h01 : 8'h00;
    end
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hi_r <= 8'h00;
        end else begin
            hi_r <= hi_nxt;
        end
    end
    // Gate and lockout flag change on the same edge
    gate_off_lock_a: assert property (lk |-> !g)
        else $error("gate high in lockout");
    ref_zero_lock_a: assert property (lk && $past(lk) |-> status_out.ref_code == 5'h00)
        else $error("reference moved in lockout");
    // Release and fall-back conditions depend on the variant
    lock_exit_a: assert property (lk && sense_in.enable_lockout_input
        && (BOOTSTRAP_LOCKOUT ? sense_in.supply_above_wake : sense_in.gate_supply_ok)
        |=> !lk)
        else $error("lockout not released");
    fall_back_a: assert property (!lk && !(sense_in.enable_lockout_input
        && (BOOTSTRAP_LOCKOUT ? sense_in.supply_above_low : sense_in.gate_supply_ok))
        |=> lk)
        else $error("no fall back to lockout");
    trip_cut_a: assert property (g && !lk && (sense_in.current_limit_comparator
        || sense_in.pwm_comparator) |=> !g)
        else $error("trip did not end on-phase");
    ref_step_a: assert property (!lk && !$past(lk)
        && status_out.ref_code != $past(status_out.ref_code)
        |-> status_out.ref_code == $past(status_out.ref_code) + 5'h01)
        else $error("reference jumped");
    ref_hold_a: assert property (!lk && status_out.ref_code == 5'h1F
        |=> lk || status_out.ref_code == 5'h1F)
        else $error("final reference left");
    done_ref_a: assert property (status_out.soft_start_done
        |-> lk || status_out.ref_code == 5'h1F)
        else $error("done before final reference");
    // Window length bounds the longest pulse
    duty_max_a: assert property (hi_r <= (THREE_QUARTER_DUTY ? 3 : 2) * OSC_DIV)
        else $error("gate pulse too long");
    first_edge_a: assert property ($fell(lk) && !$past(sense_in.pwm_comparator)
        && !$past(sense_in.current_limit_comparator) |-> g)
        else $error("gate late at start");
    release_c: cover property ($fell(lk));
    trip_c: cover property (g && sense_in.current_limit_comparator);
    done_c: cover property ($rose(status_out.soft_start_done));
endmodule // cmpwm_chk

bind cmpwm_core cmpwm_chk #(
    .BOOTSTRAP_LOCKOUT(BOOTSTRAP_LOCKOUT),
    .THREE_QUARTER_DUTY(THREE_QUARTER_DUTY),
    .OSC_DIV(OSC_DIV)
) u_chk (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .sense_in(sense_in),
    .gate_drive_output_out(gate_drive_output_out),
    .status_out(status_out)
);

// ---- tb/cmpwm_fet_model.sv ----
// Power switch and sense resistor
module cmpwm_fet_model (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic gate_in,
    input wire logic [7:0] limit_in,
    output logic trip_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] on_r;
    logic [7:0] on_nxt;
    // Current ramps while on, zero limit never trips
    always_comb begin
        on_nxt = gate_in ? on_r + 8'h01 : 8'h00;
    end
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            on_r <= 8'h00;
        end else begin
            on_r <= on_nxt;
        end
    end
    // Sense voltage collapses once the switch opens
    assign trip_out = gate_in && limit_in != 8'h00 && on_r >= limit_in;
endmodule // cmpwm_fet_model

// ---- tb/cmpwm_core_bench.sv ----
module cmpwm_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import cmpwm_pkg::*;
    localparam int unsigned DIV = 4;
    logic core_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    cmpwm_sense_t drv = '0;
    cmpwm_sense_t sense;
    cmpwm_status_t st;
    logic trip;
    logic gate;
    logic [7:0] lim = 8'h00;
    logic [7:0] hi;
    logic [7:0] rs;
    logic [7:0] hi_alt;
    logic gate_alt;
    cmpwm_status_t st_alt;
    int errors = 0;
    int checks_done = 0;
    int n;
    always #2 core_clk_in = ~core_clk_in;
    // Trip line comes from the switch model
    always_comb begin
        sense = drv;
        sense.current_limit_comparator = trip;
    end
    cmpwm_core #(.OSC_DIV(DIV), .SS_TIME_CYCLES(3100), .SS_STEPS(31)) u_dut (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .sense_in(sense),
        .gate_drive_output_out(gate),
        .status_out(st)
    );
    cmpwm_fet_model u_fet (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .gate_in(gate),
        .limit_in(lim),
        .trip_out(trip)
    );
    // Other variant: no bootstrap lockout, three-quarter window, no sense resistor
    cmpwm_core #(
        .BOOTSTRAP_LOCKOUT(1'b0),
        .THREE_QUARTER_DUTY(1'b1),
        .OSC_DIV(DIV),
        .SS_TIME_CYCLES(3100),
        .SS_STEPS(31)
    ) u_dut_alt (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .sense_in(drv),
        .gate_drive_output_out(gate_alt),
        .status_out(st_alt)
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Wait n edges, then sample where settled
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk_in);
        @(negedge core_clk_in);
    endtask
    // All three supply flags move together, as a real rail would
    task automatic supply(input logic en, input logic up);
        @(posedge core_clk_in);
        drv.enable_lockout_input <= en;
        drv.supply_above_wake <= up;
        drv.supply_above_low <= up;
        drv.gate_supply_ok <= up;
    endtask
    // Any two whole periods give the same totals
    task automatic measure();
        logic prev;
        hi = 8'h00;
        rs = 8'h00;
        hi_alt = 8'h00;
        @(negedge core_clk_in);
        prev = gate;
        repeat (8 * DIV) begin
            @(negedge core_clk_in);
            hi = hi + 8'(gate);
            hi_alt = hi_alt + 8'(gate_alt);
            rs = rs + 8'(gate && !prev);
            prev = gate;
        end
    endtask
    task automatic t_lockout();
        supply(1'b0, 1'b1);
        tick(20);
        chk(8'(gate), 8'h00);
        chk(8'(st.ref_code), 8'h00);
        supply(1'b1, 1'b0);
        tick(20);
        chk(8'(st.undervoltage_lockout), 8'h01);
        $display("lockout test done");
    endtask
    // Gate supply alone wakes only the variant without bootstrap lockout
    task automatic t_variant();
        @(posedge core_clk_in);
        drv.gate_supply_ok <= 1'b1;
        tick(2);
        chk(8'(st.undervoltage_lockout), 8'h01);
        chk(8'(st_alt.undervoltage_lockout), 8'h00);
        chk(8'(gate_alt), 8'h01);
        $display("variant test done");
    endtask
    task automatic t_start();
        supply(1'b1, 1'b1);
        tick(1);
        chk(8'(st.undervoltage_lockout), 8'h00);
        chk(8'(gate), 8'h01);
        measure();
        chk(hi, 8'(4 * DIV));
        chk(rs, 8'h02);
        chk(hi_alt, 8'(6 * DIV));
        $display("start test done");
    endtask
    // Limit and comparator change on the rising edge, like every input
    task automatic t_trip();
        @(posedge core_clk_in);
        lim <= 8'h03;
        tick(4 * DIV);
        measure();
        chk(hi, 8'h08);
        chk(rs, 8'h02);
        chk(hi_alt, 8'(6 * DIV));
        @(posedge core_clk_in);
        lim <= 8'h00;
        drv.pwm_comparator <= 1'b1;
        tick(4 * DIV);
        measure();
        chk(hi, 8'h00);
        chk(hi_alt, 8'h00);
        @(posedge core_clk_in);
        drv.pwm_comparator <= 1'b0;
        $display("trip test done");
    endtask
    task automatic t_sag();
        chk(8'(st.soft_start_done), 8'h00);
        supply(1'b1, 1'b0);
        tick(2);
        chk(8'(st.undervoltage_lockout), 8'h01);
        chk(8'(st_alt.undervoltage_lockout), 8'h01);
        chk(8'(gate), 8'h00);
        $display("sag test done");
    endtask
    task automatic t_ramp();
        supply(1'b1, 1'b1);
        tick(2);
        chk(8'(st.ref_code), 8'h00);
        n = 0;
        while (st.soft_start_done !== 1'b1) begin
            if (n > 4000) begin
                errors++;
                end_of_test();
            end
            tick(0);
            n++;
        end
        chk(8'(n >= 3095 && n <= 3105), 8'h01);
        tick(200);
        chk(8'(st.ref_code), 8'h1F);
        measure();
        chk(hi, 8'(4 * DIV));
        chk(hi_alt, 8'(6 * DIV));
        $display("ramp test done");
    endtask
    task automatic t_hiccup();
        supply(1'b0, 1'b1);
        tick(2);
        chk(8'(gate), 8'h00);
        supply(1'b1, 1'b1);
        tick(2);
        chk(8'(st.undervoltage_lockout), 8'h00);
        chk(8'(st.ref_code), 8'h00);
        chk(8'(st.soft_start_done), 8'h00);
        $display("hiccup test done");
    endtask
    initial begin
        repeat (3) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        t_lockout();
        t_variant();
        t_start();
        t_trip();
        t_sag();
        t_ramp();
        t_hiccup();
        end_of_test();
    end
endmodule // cmpwm_core_bench
